//--- dv/msd_host.sv
// msd_host: strap drivers and debug host at the pins; assumes the bench owns rst
`timescale 1ns/100ps
`default_nettype none
module msd_host (input wire logic rst, output logic background_debug_pin_in, mode_select_high_pin, mode_select_low_pin);
  // straps low in reset pick special single-chip; the serial line then idles high
  assign background_debug_pin_in = !rst;
  assign {mode_select_high_pin, mode_select_low_pin} = 2'h0;
endmodule
`default_nettype wire

//--- dv/msd_sva.sv
// msd_sva: checker on msd_top ports; assumes one clock and sync reset
`timescale 1ns/100ps
`default_nettype none
module msd_sva import msd_pkg::*; (input wire logic core_clk, rst, psel, stop_mode, hw_cmd_valid, hw_cmd_exec,
  input wire logic fw_cmd_exec, debug_enabled, debug_active, debug_rom_select, special_mode,
  input wire logic [15:0] cpu_addr, input wire logic [1:0] mode_select, port_b_cfg);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_fw_gate: assert property (fw_cmd_exec |-> debug_enabled && debug_active) else $error("fw gate");
  chk_stop_quiet: assert property (stop_mode |=> !hw_cmd_exec && !fw_cmd_exec) else $error("stop");
  chk_hw_run: assert property (hw_cmd_valid && !stop_mode |-> ##[0:4] hw_cmd_exec) else $error("hw");
  chk_rom_top: assert property (debug_rom_select |-> $past(cpu_addr) >= MSD_DBG_ROM_BASE) else $error("rom top");
  chk_rom_special: assert property (debug_rom_select |-> special_mode) else $error("rom mode");
  chk_no_special: assert property (!special_mode |=> !special_mode) else $error("to special");
  // a few cycles of grace after reset cover the strap synchroniser
  chk_mode_hold: assert property (!psel && !$past(rst, 4) |=> $stable(mode_select)) else $error("hold");
  chk_single_gpio: assert property (mode_select == MSD_MS_SINGLE |->
    port_b_cfg == MSD_PORT_GPIO) else $error("gpio");
endmodule
bind msd_top msd_sva u_sva (.*);
`default_nettype wire

//--- dv/msd_top_tb_top.sv
// msd_top_tb_top: apb bench for msd_top; assumes msd_host straps special single-chip
`timescale 1ns/100ps
`default_nettype none
module msd_top_tb_top import msd_pkg::*;;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, stop_mode = 0, hw_cmd_valid = 1, fw_cmd_valid = 1;
  logic pready, pslverr, special_mode, debug_enabled, debug_active, debug_pin_serial, hw_cmd_exec, fw_cmd_exec;
  logic debug_rom_select, background_debug_pin_in, mode_select_high_pin, mode_select_low_pin;
  logic [31:0] pwdata = 0, prdata, r;
  logic err;
  logic [11:0] paddr = 0;
  logic [3:0] pstrb = 4'hF;
  logic [15:0] cpu_addr = 16'hFF00;
  logic [1:0] mode_select, port_a_cfg, port_b_cfg;
  int fail_count = 0, checks = 0;
  always #5 core_clk = ~core_clk;
  msd_host host (.*);
  msd_top dut (.*);
  task chk(input string n, input logic [7:0] e, g);
    checks++;
    if (e !== g) begin fail_count++; $display("ERROR %s expected %h seen %h", n, e, g); end
  endtask
  task settle;
    repeat (2) @(posedge core_clk);
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge core_clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge core_clk) penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    settle;
  endtask
  task end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task t_reset;
    apb(MSD_OFF_MODE, 0, 0);
    chk("mode", 8'h19, r[7:0]);
    chk("debug", 8'h3, {6'h0, debug_enabled, debug_active});
    chk("rom", 8'h1, {7'h0, debug_rom_select});
    chk("serial", 8'h1, {7'h0, debug_pin_serial});
    chk("ports", 8'h0, {4'h0, port_a_cfg, port_b_cfg});
    chk("exec", 8'h3, {6'h0, hw_cmd_exec, fw_cmd_exec});
    $display("t_reset done");
  endtask
  task t_debug;
    cpu_addr <= 16'h8000;
    settle;
    chk("rom low", 8'h0, {7'h0, debug_rom_select});
    cpu_addr <= 16'hFF00;
    stop_mode <= 1;
    settle;
    chk("stop", 8'h0, {6'h0, hw_cmd_exec, fw_cmd_exec});
    stop_mode <= 0;
    apb(MSD_OFF_DBG, 1, 8'h1);
    chk("inactive", 8'h2, {6'h0, hw_cmd_exec, fw_cmd_exec});
    apb(MSD_OFF_DBG, 0, 0);
    chk("dbg read", 8'h1, r[7:0]);
    apb(MSD_OFF_DBG, 1, 8'h3);
    apb(12'h004, 0, 0);
    chk("bad addr", 8'h1, {7'h0, err});
    $display("t_debug done");
  endtask
  task t_mode;
    apb(MSD_OFF_MODE, 1, 8'h60);
    chk("special rewrite", 8'h3, {6'h0, mode_select});
    apb(MSD_OFF_MODE, 1, 8'h99);
    chk("first exit", 8'h1, {7'h0, special_mode});
    apb(MSD_OFF_MODE, 1, 8'h99);
    chk("second exit", 8'h0, {7'h0, special_mode});
    chk("rom off", 8'h0, {7'h0, debug_rom_select});
    apb(MSD_OFF_MODE, 1, 8'h20);
    chk("to special", 8'h0, {7'h0, special_mode});
    apb(MSD_OFF_MODE, 1, 8'hA0);
    chk("one change", 8'h1, {6'h0, mode_select});
    chk("narrow ports", 8'h6, {4'h0, port_a_cfg, port_b_cfg});
    apb(MSD_OFF_MODE, 1, 8'hE0);
    chk("locked", 8'h1, {6'h0, mode_select});
    apb(MSD_OFF_MODE, 0, 0);
    chk("mode read", 8'hA0, r[7:0]);
    $display("t_mode done");
  endtask
  initial begin repeat (10) @(posedge core_clk); rst <= 0; t_reset; t_debug; t_mode; end_of_test; end
  initial begin repeat (3000) @(posedge core_clk); fail_count++; end_of_test; end
endmodule
`default_nettype wire

//--- include/msd_pkg.sv
// msd_pkg: shared constants for the mode select and debug gating block
// assumes a 32-bit apb slave with byte addresses and one register per word
package msd_pkg;
  localparam int MSD_IDX_MODE = 11;
  localparam logic [11:0] MSD_OFF_MODE = 12'h02C;   // index 0x0B, byte address 4*index
  localparam logic [11:0] MSD_OFF_DBG = 12'h100;    // debug control/status
  localparam int MSD_BIT_EXIT = 7;
  localparam int MSD_BIT_MODE_SELECT_HIGH = 6;
  localparam int MSD_BIT_MODE_SELECT_LOW = 5;
  localparam int MSD_BIT_STR = 4;
  localparam int MSD_BIT_VIS = 3;
  localparam int MSD_BIT_BSW = 2;
  localparam int MSD_BIT_EME = 0;
  localparam int MSD_DBG_BIT_EN = 0;
  localparam int MSD_DBG_BIT_ACT = 1;
  localparam logic MSD_RST_STR = 1'b1;
  localparam logic MSD_RST_BSW = 1'b0;
  localparam logic [7:0] MSD_MODE_WMASK = 8'hFD;
  localparam logic [1:0] MSD_MS_SINGLE = 2'h0;
  localparam logic [1:0] MSD_MS_NARROW = 2'h1;
  localparam logic [1:0] MSD_MS_PERIPH = 2'h2;
  localparam logic [1:0] MSD_MS_WIDE = 2'h3;
  localparam logic [15:0] MSD_DBG_ROM_BASE = 16'hFF00;
  localparam int MSD_SYNC_STAGES = 3;
  typedef enum logic [1:0] {MSD_PORT_GPIO, MSD_PORT_NARROW, MSD_PORT_BUS} msd_port_cfg_t;
endpackage

//--- logic/msd_sync.sv
// msd_sync: three-flop synchroniser with agreement filter
// assumes an asynchronous pin input and one clock domain
`timescale 1ns/100ps
`default_nettype none
module msd_sync
  import msd_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic level_q
);
  logic [MSD_SYNC_STAGES-1:0] sh_q;

  // first stage feeds only the second; level moves when stages two and three agree
  // the chain is never reset: straps must be seen while reset is held
  always_ff @(posedge core_clk) begin
    sh_q <= {sh_q[MSD_SYNC_STAGES-2:0], pin_in};
  end

  // an undecided level during reset falls back to the default
  always_ff @(posedge core_clk) begin
    if (sh_q[1] == sh_q[2]) begin
      level_q <= sh_q[2];
    end else if (rst) begin
      level_q <= RESET_VAL;
    end
  end
endmodule
`default_nettype wire

//--- logic/msd_top.sv
// msd_top: operating mode register, strap capture and debug command gating
// assumes straps stable around reset release; serial debug protocol lives elsewhere
// Notes on behaviour
// - eight-bit mode register: exit, mode high/low, stretch, visibility, stop-in-wait, 0, emulation
// - mode-select reset bits follow the strapped mode
// - strapped mode-select levels set port A as bus, narrow or gpio and port B as bus or gpio
// - background pin is a strap at reset, then the serial debug line
// - in normal mode writes leading into special mode are rejected
// - normal mode allows one change to another normal mode, then locks
// - special mode leaves only after exit bit written 1 twice
// - special single-chip reset starts debug enabled and active
// - special single-chip maps debug rom over the top page
// - hardware debug commands run even when debug is not active
// - firmware debug commands run only when enabled and active
// - in stop mode the debug facility ignores all commands
// - three strap bits decode to seven modes, 110 forced special peripheral
// - first write of exit bit in special mode is ignored
// - special mode allows unlimited mode-select rewrites
`timescale 1ns/100ps
`default_nettype none
module msd_top
  import msd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic background_debug_pin_in,
  input wire logic mode_select_high_pin,
  input wire logic mode_select_low_pin,
  input wire logic stop_mode,
  input wire logic hw_cmd_valid,
  input wire logic fw_cmd_valid,
  input wire logic [15:0] cpu_addr,
  output logic special_mode,
  output logic [1:0] mode_select,
  output logic [1:0] port_a_cfg,
  output logic [1:0] port_b_cfg,
  output logic debug_enabled,
  output logic debug_active,
  output logic debug_pin_serial,
  output logic hw_cmd_exec,
  output logic fw_cmd_exec,
  output logic debug_rom_select
);
  logic background_debug_pin_s;
  logic mode_select_high_s;
  logic mode_select_low_s;
  logic strap_special;
  logic [1:0] strap_sel;
  logic start_debug;
  logic [7:0] mode_rst_val;
  logic [7:0] wbyte;
  logic [1:0] wsel;
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [7:0] mode_next;
  logic [1:0] cur_sel;
  logic [1:0] sel_next;
  logic exit_armed_q;
  logic exit_armed_d;
  logic changed_q;
  logic changed_d;
  logic dbg_en_d;
  logic dbg_act_d;
  logic dbg_en_next;
  logic dbg_act_next;
  logic hit_mode;
  logic hit_dbg;
  logic access_first;
  logic commit;
  logic mode_wr;
  logic dbg_wr;
  logic [31:0] read_word;
  logic rom_next;
  msd_port_cfg_t port_a_d;
  msd_port_cfg_t port_b_d;

  // straps pass the same three-flop filter as any pin
  msd_sync #(
    .RESET_VAL(1'b1)
  ) u_sync_background_debug_pin (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(background_debug_pin_in),
    .level_q(background_debug_pin_s)
  );

  msd_sync #(
    .RESET_VAL(1'b0)
  ) u_sync_mode_select_high (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(mode_select_high_pin),
    .level_q(mode_select_high_s)
  );

  msd_sync #(
    .RESET_VAL(1'b0)
  ) u_sync_mode_select_low (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(mode_select_low_pin),
    .level_q(mode_select_low_s)
  );

  // code 110 is reserved and forced to special peripheral
  always_comb begin
    strap_sel = {mode_select_high_s, mode_select_low_s};
    strap_special = !background_debug_pin_s;
    if (background_debug_pin_s && mode_select_high_s && !mode_select_low_s) begin
      strap_special = 1'b1;
    end
  end

  assign start_debug = strap_special && (strap_sel == MSD_MS_SINGLE);

  // special modes open the visibility and emulation bits
  always_comb begin
    mode_rst_val = 8'h00;
    mode_rst_val[MSD_BIT_EXIT] = !strap_special;
    mode_rst_val[MSD_BIT_MODE_SELECT_HIGH] = strap_sel[1];
    mode_rst_val[MSD_BIT_MODE_SELECT_LOW] = strap_sel[0];
    mode_rst_val[MSD_BIT_STR] = MSD_RST_STR;
    mode_rst_val[MSD_BIT_VIS] = strap_special;
    mode_rst_val[MSD_BIT_BSW] = MSD_RST_BSW;
    mode_rst_val[MSD_BIT_EME] = strap_special;
  end

  always_comb begin
    hit_mode = 1'b0;
    hit_dbg = 1'b0;
    if (paddr == MSD_OFF_MODE) begin
      hit_mode = 1'b1;
    end else if (paddr == MSD_OFF_DBG) begin
      hit_dbg = 1'b1;
    end
  end

  // a write lands only on the edge where pready is seen high
  assign access_first = psel && penable && !pready;
  assign commit = psel && penable && pready;
  assign mode_wr = commit && pwrite && hit_mode && pstrb[0];
  assign dbg_wr = commit && pwrite && hit_dbg && pstrb[0];
  assign wbyte = pwdata[7:0] & MSD_MODE_WMASK;
  assign wsel = {wbyte[MSD_BIT_MODE_SELECT_HIGH], wbyte[MSD_BIT_MODE_SELECT_LOW]};
  assign cur_sel = {mode_q[MSD_BIT_MODE_SELECT_HIGH], mode_q[MSD_BIT_MODE_SELECT_LOW]};

  // peripheral has no normal variant, so an exit that selects it is held back
  always_comb begin
    mode_d = mode_q;
    exit_armed_d = exit_armed_q;
    changed_d = changed_q;
    if (mode_wr) begin
      if (!mode_q[MSD_BIT_EXIT]) begin
        // every field but the exit bit is free while special
        mode_d = wbyte;
        mode_d[MSD_BIT_EXIT] = 1'b0;
        if (wbyte[MSD_BIT_EXIT]) begin
          if (!exit_armed_q) begin
            exit_armed_d = 1'b1;
          end else if (wsel != MSD_MS_PERIPH) begin
            mode_d[MSD_BIT_EXIT] = 1'b1;
          end
        end
      end else if (!wbyte[MSD_BIT_EXIT] || (wsel == MSD_MS_PERIPH)) begin
        mode_d = mode_q;
      end else if ((wsel != cur_sel) && changed_q) begin
        mode_d = mode_q;
      end else begin
        mode_d = wbyte;
        if (wsel != cur_sel) begin
          changed_d = 1'b1;
        end
      end
    end
  end

  assign mode_next = rst ? mode_rst_val : mode_d;
  assign sel_next = {mode_next[MSD_BIT_MODE_SELECT_HIGH], mode_next[MSD_BIT_MODE_SELECT_LOW]};

  // reset value tracks the filtered straps until release, then holds
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q <= mode_rst_val;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      exit_armed_q <= 1'b0;
    end else begin
      exit_armed_q <= exit_armed_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      changed_q <= 1'b0;
    end else begin
      changed_q <= changed_d;
    end
  end

  always_ff @(posedge core_clk) begin
    special_mode <= !mode_next[MSD_BIT_EXIT];
    mode_select <= sel_next;
  end

  // ports follow the mode in force, the strapped one until a write
  always_comb begin
    port_a_d = MSD_PORT_BUS;
    port_b_d = MSD_PORT_BUS;
    if (sel_next == MSD_MS_SINGLE) begin
      port_a_d = MSD_PORT_GPIO;
      port_b_d = MSD_PORT_GPIO;
    end else if (sel_next == MSD_MS_NARROW) begin
      port_a_d = MSD_PORT_NARROW;
    end
  end

  always_ff @(posedge core_clk) begin
    port_a_cfg <= port_a_d;
    port_b_cfg <= port_b_d;
  end

  // debug enable and active come up set only in special single-chip
  always_comb begin
    dbg_en_d = debug_enabled;
    dbg_act_d = debug_active;
    if (dbg_wr) begin
      dbg_en_d = pwdata[MSD_DBG_BIT_EN];
      dbg_act_d = pwdata[MSD_DBG_BIT_ACT];
    end
  end

  assign dbg_en_next = rst ? start_debug : dbg_en_d;
  assign dbg_act_next = rst ? start_debug : dbg_act_d;

  always_ff @(posedge core_clk) begin
    debug_enabled <= dbg_en_next;
    debug_active <= dbg_act_next;
  end

  // hardware commands need no active debug, nothing runs in stop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hw_cmd_exec <= 1'b0;
    end else begin
      hw_cmd_exec <= hw_cmd_valid && !stop_mode;
    end
  end

  // gated on the next enable state so the flag never outruns the gate
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fw_cmd_exec <= 1'b0;
    end else begin
      fw_cmd_exec <= fw_cmd_valid && !stop_mode && dbg_en_next && dbg_act_next;
    end
  end

  assign rom_next = !mode_next[MSD_BIT_EXIT] && (sel_next == MSD_MS_SINGLE) && (cpu_addr >= MSD_DBG_ROM_BASE);

  always_ff @(posedge core_clk) begin
    debug_rom_select <= rom_next;
  end

  // once reset is gone the background pin belongs to the serial line
  always_ff @(posedge core_clk) begin
    if (rst) begin
      debug_pin_serial <= 1'b0;
    end else begin
      debug_pin_serial <= 1'b1;
    end
  end

  always_comb begin
    read_word = 32'h00000000;
    if (hit_mode) begin
      read_word[7:0] = mode_q;
    end else if (hit_dbg) begin
      read_word[MSD_DBG_BIT_EN] = debug_enabled;
      read_word[MSD_DBG_BIT_ACT] = debug_active;
    end
  end

  // one wait state keeps pready and prdata straight from flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= access_first;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (access_first && !pwrite) begin
      prdata <= read_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access_first && !(hit_mode || hit_dbg);
    end
  end
endmodule
`default_nettype wire
